// >>> hdl/spi_nvram_command_access.sv
// spi slave command engine of a byte addressed nonvolatile memory
`timescale 1ns/1ps
// Summary of operation
// - array writes need latch; pin never guards array
// - pin enable low: protect pin ignored
// - status write blocked if enable set & pin low, or no latch
// - protect pin guards status register only
// - opcode 05h shifts out status byte
// - opcode 01h updates enable and block bits
// - three address bytes, low 20 bits used
// - address advances per byte, wraps to zero
// - write byte msb first, committed after eighth
// - protected address stops increment, drops data
// - read data msb first, serial input ignored
// - chip select rise ends reads, floats output
// - 0Bh adds one dummy byte, then reads
// - 42h writes special sector from low byte
// - 4Bh reads special sector, incrementing
// - latch set by 06h, cleared ending writes
// - block bits protect quarter, half, all
// - status bit layout with fixed bits
module spi_nvram_command_access (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output spi_nvram_pkg::mem_req_t mem_wr,
  output logic mem_rd_req,
  output spi_nvram_pkg::mem_req_t mem_rd,
  input wire logic [7:0] mem_rd_data,
  output logic wr_overrun,
  output logic [7:0] status_byte
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic [3:0] pin_m_q;
  logic [3:0] pin_s_q;
  logic [3:0] pin_d_q;
  wire rst_n = rst_q[1];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'b1};
  end

  // all stages reset high, and sck edges need chip select low, so no false edge follows reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_q <= 4'hf;
      pin_s_q <= 4'hf;
      pin_d_q <= 4'hf;
    end else begin
      pin_m_q <= {cs_n, sck, si, wp_n};
      pin_s_q <= pin_m_q;
      pin_d_q <= pin_s_q;
    end
  end

  wire cs_s = pin_s_q[spi_nvram_pkg::PIN_CS];
  wire si_s = pin_s_q[spi_nvram_pkg::PIN_SI];
  wire wp_s = pin_s_q[spi_nvram_pkg::PIN_WP];
  wire sck_s = pin_s_q[spi_nvram_pkg::PIN_SCK];
  wire sck_d = pin_d_q[spi_nvram_pkg::PIN_SCK];
  wire cs_rise = cs_s & ~pin_d_q[spi_nvram_pkg::PIN_CS];
  wire sck_rise = ~cs_s & sck_s & ~sck_d;
  wire sck_fall = ~cs_s & ~sck_s & sck_d;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic is_protected(input logic [19:0] a,
                                        input logic [1:0] bp);
    is_protected = (bp == spi_nvram_pkg::BP_ALL) ||
      (bp == spi_nvram_pkg::BP_HALF && a >= spi_nvram_pkg::HALF_BASE) ||
      (bp == spi_nvram_pkg::BP_QUARTER &&
       a >= spi_nvram_pkg::QUARTER_BASE);
  endfunction : is_protected

  // the special sector wraps inside its own 256 bytes
  function automatic logic [19:0] addr_inc(input logic [19:0] a,
                                           input logic sector);
    addr_inc = sector ? {a[19:8], a[7:0] + 8'h01} : a + 20'h00001;
  endfunction : addr_inc

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spi_nvram_pkg::state_t state_q;
  logic [2:0] bit_cnt_q;
  logic [1:0] addr_cnt_q;
  logic [6:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] rd_buf_q;
  logic [19:0] addr_q;
  logic is_write_q;
  logic fast_q;
  logic sector_q;
  logic from_mem_q;
  logic halt_q;
  logic wr_frame_q;
  logic fetch_pend_q;
  logic rd_req_q;
  logic rd_valid_q;
  logic so_oe_q;
  logic overrun_q;
  logic ppe_q;
  logic [1:0] bp_q;
  logic latch_q;
  spi_nvram_pkg::mem_req_t rd_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [7:0] rx_byte = {rx_q, si_s};
  wire byte_done = sck_rise & (bit_cnt_q == spi_nvram_pkg::BIT_LAST);
  wire in_op = state_q == spi_nvram_pkg::ST_OPCODE;
  wire op_done = byte_done & in_op;
  wire latch_set_go = op_done & (rx_byte == spi_nvram_pkg::OPC_SET_LATCH);
  wire status_go = op_done & (rx_byte == spi_nvram_pkg::OPC_STATUS_RD);
  wire addr_done = byte_done & (state_q == spi_nvram_pkg::ST_ADDR) &
                   (addr_cnt_q == spi_nvram_pkg::ADDR_BYTE_LAST);
  wire dummy_done = byte_done & (state_q == spi_nvram_pkg::ST_DUMMY);
  wire wp_block = ppe_q & ~wp_s;
  wire sr_ok = latch_q & ~wp_block;
  wire sr_go = byte_done & (state_q == spi_nvram_pkg::ST_STATUS_WR);
  wire rx_ppe_bit = rx_byte[spi_nvram_pkg::SR_PPE];
  wire addr_blocked = ~sector_q & is_protected(addr_q, bp_q);
  wire wdata_done = byte_done & (state_q == spi_nvram_pkg::ST_WDATA);
  wire wr_allowed = latch_q & ~halt_q & ~addr_blocked;
  wire fifo_in_ready;
  wire mem_commit = wdata_done & wr_allowed & fifo_in_ready;
  wire addr_step = wdata_done & wr_allowed;
  wire out_phase = state_q == spi_nvram_pkg::ST_RDATA;
  wire out_load = sck_fall & out_phase &
                  (bit_cnt_q == spi_nvram_pkg::BIT_FIRST);
  wire fetch_go = fetch_pend_q | (out_load & from_mem_q);

  assign status_byte = spi_nvram_pkg::SR_FIXED |
    {ppe_q, 3'h0, bp_q, latch_q, 1'b0};
  assign so = tx_q[7];
  assign so_oe = so_oe_q;
  assign mem_rd_req = rd_req_q;
  assign mem_rd = rd_q;
  assign wr_overrun = overrun_q;

  // ----------------------------------------------------------------
  // bit counter and receive shifter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= spi_nvram_pkg::BIT_FIRST;
      rx_q <= 7'h00;
    end else if (cs_s) begin
      bit_cnt_q <= spi_nvram_pkg::BIT_FIRST;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q <= rx_byte[6:0];
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ppe_q <= spi_nvram_pkg::PPE_RST;
      bp_q <= spi_nvram_pkg::BP_RST;
      latch_q <= spi_nvram_pkg::LATCH_RST;
    end else begin
      if (latch_set_go) latch_q <= 1'b1;
      else if (cs_rise && wr_frame_q) latch_q <= 1'b0;
      if (sr_go && sr_ok) begin
        ppe_q <= rx_ppe_bit;
        bp_q <= {rx_byte[spi_nvram_pkg::SR_BP_HIGH],
                 rx_byte[spi_nvram_pkg::SR_BP_LOW]};
      end
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= spi_nvram_pkg::ST_OPCODE;
      addr_cnt_q <= 2'h0;
      is_write_q <= 1'b0;
      fast_q <= 1'b0;
      sector_q <= 1'b0;
      from_mem_q <= 1'b0;
      wr_frame_q <= 1'b0;
      fetch_pend_q <= 1'b0;
    end else if (cs_s) begin
      state_q <= spi_nvram_pkg::ST_OPCODE;
      addr_cnt_q <= 2'h0;
      wr_frame_q <= 1'b0;
      fetch_pend_q <= 1'b0;
    end else begin
      fetch_pend_q <= addr_done & ~is_write_q & ~fast_q | dummy_done;
      if (op_done) begin
        from_mem_q <= 1'b1;
        case (rx_byte)
          spi_nvram_pkg::OPC_STATUS_RD: begin
            state_q <= spi_nvram_pkg::ST_RDATA;
            from_mem_q <= 1'b0;
          end
          spi_nvram_pkg::OPC_STATUS_WR: begin
            state_q <= spi_nvram_pkg::ST_STATUS_WR;
            wr_frame_q <= 1'b1;
          end
          spi_nvram_pkg::OPC_WRITE, spi_nvram_pkg::OPC_SECTOR_WR: begin
            state_q <= spi_nvram_pkg::ST_ADDR;
            wr_frame_q <= 1'b1;
          end
          spi_nvram_pkg::OPC_READ, spi_nvram_pkg::OPC_FAST_READ,
          spi_nvram_pkg::OPC_SECTOR_RD: begin
            state_q <= spi_nvram_pkg::ST_ADDR;
          end
          default: begin
            state_q <= spi_nvram_pkg::ST_IGNORE;
          end
        endcase
        is_write_q <= rx_byte == spi_nvram_pkg::OPC_WRITE ||
                      rx_byte == spi_nvram_pkg::OPC_SECTOR_WR;
        fast_q <= rx_byte == spi_nvram_pkg::OPC_FAST_READ;
        sector_q <= rx_byte == spi_nvram_pkg::OPC_SECTOR_WR ||
                    rx_byte == spi_nvram_pkg::OPC_SECTOR_RD;
      end else if (byte_done) begin
        case (state_q)
          spi_nvram_pkg::ST_ADDR: begin
            addr_cnt_q <= addr_cnt_q + 2'h1;
            if (addr_done) begin
              if (is_write_q) state_q <= spi_nvram_pkg::ST_WDATA;
              else if (fast_q) state_q <= spi_nvram_pkg::ST_DUMMY;
              else state_q <= spi_nvram_pkg::ST_RDATA;
            end
          end
          spi_nvram_pkg::ST_DUMMY: begin
            state_q <= spi_nvram_pkg::ST_RDATA;
          end
          spi_nvram_pkg::ST_STATUS_WR: begin
            state_q <= spi_nvram_pkg::ST_IGNORE;
          end
          default: begin
            state_q <= state_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // address counter and write halt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= spi_nvram_pkg::ADDR_ZERO;
      halt_q <= 1'b0;
    end else if (cs_s) begin
      halt_q <= 1'b0;
    end else if (byte_done && state_q == spi_nvram_pkg::ST_ADDR) begin
      addr_q <= {addr_q[11:0], rx_byte};
    end else if (wdata_done) begin
      if (wr_allowed) addr_q <= addr_inc(addr_q, sector_q);
      else halt_q <= 1'b1;
    end else if (fetch_go) begin
      addr_q <= addr_inc(addr_q, sector_q);
    end
  end

  // ----------------------------------------------------------------
  // read fetch and output shifter
  // ----------------------------------------------------------------
  // the next byte is fetched as soon as the current one is loaded,
  // so the array has a whole byte time to answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_req_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_q <= '0;
      rd_buf_q <= 8'h00;
      tx_q <= 8'h00;
      so_oe_q <= 1'b0;
    end else begin
      rd_req_q <= fetch_go;
      rd_valid_q <= rd_req_q;
      if (fetch_go) rd_q <= '{sector_q, addr_q, 8'h00};
      if (status_go) rd_buf_q <= status_byte;
      else if (rd_valid_q) rd_buf_q <= mem_rd_data;
      if (cs_s) begin
        so_oe_q <= 1'b0;
      end else if (out_load) begin
        tx_q <= rd_buf_q;
        so_oe_q <= 1'b1;
      end else if (sck_fall && out_phase) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  // a full fifo cannot stall the host, so the byte is dropped
  // and the overrun flag tells the system about it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) overrun_q <= 1'b0;
    else if (wdata_done && wr_allowed && !fifo_in_ready) overrun_q <= 1'b1;
  end

  nvram_write_fifo #(
    .WIDTH($bits(spi_nvram_pkg::mem_req_t)),
    .DEPTH(spi_nvram_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(mem_commit),
    .in_ready(fifo_in_ready),
    .in_data({sector_q, addr_q, rx_byte}),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_so_release;
    @(posedge sys_clk) disable iff (!rst_n) cs_s |=> !so_oe_q;
  endproperty
  a_so_release: assert property (p_so_release)
    else $error("output still driven with chip select high");

  property p_latch_set;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(latch_q) |-> $past(latch_set_go);
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("write latch set without its opcode");

  property p_latch_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      cs_rise && wr_frame_q |=> !latch_q;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("write latch not cleared after write frame");

  property p_sr_block;
    @(posedge sys_clk) disable iff (!rst_n)
      sr_go && (!latch_q || (ppe_q && !wp_s)) |=> $stable(status_byte);
  endproperty
  a_sr_block: assert property (p_sr_block)
    else $error("status changed by a blocked write");

  property p_pin_ignored;
    @(posedge sys_clk) disable iff (!rst_n)
      sr_go && latch_q && !ppe_q |=> ppe_q == $past(rx_ppe_bit);
  endproperty
  a_pin_ignored: assert property (p_pin_ignored)
    else $error("status write refused while pin disabled");

  property p_commit_latch;
    @(posedge sys_clk) disable iff (!rst_n) mem_commit |-> latch_q;
  endproperty
  a_commit_latch: assert property (p_commit_latch)
    else $error("array write without write latch");

  property p_halt_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      halt_q && !cs_s |=> $stable(addr_q) && !mem_commit;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halted write burst still advancing");

  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      addr_step && !sector_q && addr_q == spi_nvram_pkg::ADDR_MAX
      |=> addr_q == spi_nvram_pkg::ADDR_ZERO;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("address did not wrap to zero");

  property p_status_load;
    @(posedge sys_clk) disable iff (!rst_n)
      status_go |=> rd_buf_q == $past(status_byte);
  endproperty
  a_status_load: assert property (p_status_load)
    else $error("status byte not loaded for shifting");

  property p_read_out;
    @(posedge sys_clk) disable iff (!rst_n)
      out_load |=> so_oe_q && tx_q == $past(rd_buf_q);
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("read byte not presented on output");

endmodule : spi_nvram_command_access

// >>> pkg/spi_nvram_pkg.sv
// constants, types and layouts shared by the nvram spi command engine
package spi_nvram_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_STATUS_RD = 8'h05;
  localparam logic [7:0] OPC_STATUS_WR = 8'h01;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_SECTOR_WR = 8'h42;
  localparam logic [7:0] OPC_SECTOR_RD = 8'h4b;

  // ----------------------------------------------------------------
  // status byte layout and reset values
  // ----------------------------------------------------------------
  localparam int SR_PPE = 7;
  localparam int SR_ONE = 6;
  localparam int SR_BP_HIGH = 3;
  localparam int SR_BP_LOW = 2;
  localparam int SR_LATCH = 1;
  localparam logic [7:0] SR_FIXED = 8'h40;
  localparam logic PPE_RST = 1'b0;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic LATCH_RST = 1'b0;

  // ----------------------------------------------------------------
  // block protect encodings and address bounds
  // ----------------------------------------------------------------
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [19:0] QUARTER_BASE = 20'hc0000;
  localparam logic [19:0] HALF_BASE = 20'h80000;
  localparam logic [19:0] ADDR_MAX = 20'hfffff;
  localparam logic [19:0] ADDR_ZERO = 20'h00000;

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;
  localparam int PIN_CS = 3;
  localparam int PIN_SCK = 2;
  localparam int PIN_SI = 1;
  localparam int PIN_WP = 0;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_STATUS_WR,
    ST_IGNORE
  } state_t;

  typedef struct packed {
    logic sector;
    logic [19:0] addr;
    logic [7:0] data;
  } mem_req_t;

endpackage : spi_nvram_pkg

// >>> hdl/nvram_write_fifo.sv
// parameterised valid/ready fifo for committed write bytes
`timescale 1ns/1ps
module nvram_write_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  // depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = count_q != FULL_COUNT;
  assign out_valid = count_q != '0;
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end

endmodule : nvram_write_fifo

// >>> sim/spi_host_model.sv
// host spi controller model: chip select, clock and serial input
`timescale 1ns/1ps
module spi_host_model (
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  // sck level between frames: 0 for mode 0, 1 for mode 3
  logic idle = 1'b0;

  // ----------------------------------------------------------------
  // frame and bit tasks
  // ----------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b1;
  end

  // each command, latch-set included, goes in a frame of its own
  task automatic start();
    cs_n = 1'b0;
    #100;
  endtask : start

  // only called with chip select high, so the level change is no edge
  task automatic mode(input logic m);
    idle = m;
    sck = m;
  endtask : mode

  // so is taken late in the high phase: the device shifts after the fall
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      if (idle) sck = 1'b0;
      si = tx[i];
      #100 sck = 1'b1;
      #95 rx[i] = so;
      #5 if (!idle) sck = 1'b0;
    end
  endtask : xfer

  task automatic stop();
    #100 cs_n = 1'b1;
    si = ~si; // a released line must not keep showing the last bit
    #300;
  endtask : stop
endmodule : spi_host_model

// >>> sim/tb_top.sv
// self-checking bench for the nvram spi command engine
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic arst_n, cs_n, sck, si, wp_n, so, so_oe, mem_wr_valid, mem_wr_ready;
  logic mem_rd_req, wr_overrun;
  logic [7:0] mem_rd_data, status_byte;
  spi_nvram_pkg::mem_req_t mem_wr, mem_rd;
  spi_nvram_pkg::mem_req_t eq[$];
  logic [7:0] tq[$], rq[$], mem[logic [20:0]], arr[logic [20:0]];
  logic [20:0] k_rd;
  logic ppe = 1'b0, latch = 1'b0;
  logic [1:0] bp = 2'h0;
  logic [23:0] ra;
  logic [19:0] bases[4] = '{20'h7fffe, 20'hbfffe, 20'h7fffe, 20'h00010};
  int num_errors = 0, tests_run = 0;

  always #12.5 sys_clk = ~sys_clk;

  spi_nvram_command_access DUT (.sys_clk(sys_clk), .arst_n(arst_n),
    .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr(mem_wr), .mem_rd_req(mem_rd_req), .mem_rd(mem_rd),
    .mem_rd_data(mem_rd_data), .wr_overrun(wr_overrun),
    .status_byte(status_byte));

  // so is not driven while so_oe is low: the host then sees the inverse
  spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si),
    .so(so_oe ? so : ~so));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [20:0] key(input logic s, input logic [19:0] a);
    return s ? {1'b1, 12'h0, a[7:0]} : {1'b0, a};
  endfunction : key

  // unwritten cells hold a pattern, so a wrong address shows up
  function automatic logic [7:0] dflt(input logic [20:0] k);
    return k[7:0] ^ k[15:8] ^ {3'h0, k[20:16]};
  endfunction : dflt

  function automatic logic [31:0] norm(input spi_nvram_pkg::mem_req_t r);
    return {3'h0, r.sector, r.sector ? {12'h0, r.addr[7:0]} : r.addr, r.data};
  endfunction : norm

  function automatic logic prot(input logic [19:0] a);
    return bp == 2'h3 || (bp == 2'h2 && a >= 20'h80000) ||
      (bp == 2'h1 && a >= 20'hc0000);
  endfunction : prot

  function automatic logic [7:0] sbyte();
    return {ppe, 1'b1, 2'h0, bp, latch, 1'b0};
  endfunction : sbyte

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic results();
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // array side: one-cycle read answer, write pops checked in order
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (mem_rd_req === 1'b1) begin
      k_rd = key(mem_rd.sector, mem_rd.addr);
      mem_rd_data <= #2 arr.exists(k_rd) ? arr[k_rd] : dflt(k_rd);
    end
    if (mem_wr_valid === 1'b1 && mem_wr_ready) begin
      arr[key(mem_wr.sector, mem_wr.addr)] = mem_wr.data;
      if (eq.size() == 0) check("mem_wr_extra", 0, 1);
      else check("mem_wr", norm(eq.pop_front()), norm(mem_wr));
    end
  end

  // ----------------------------------------------------------------
  // frame tasks with the reference model
  // ----------------------------------------------------------------
  task automatic frame(input int nbits);
    logic [7:0] r;
    rq = {};
    @(posedge sys_clk) #2 host.start();
    for (int i = 0; nbits > 0; i++) begin
      host.xfer(tq[i], nbits > 8 ? 8 : nbits, r);
      rq.push_back(r);
      nbits -= 8;
    end
    host.stop();
    check("so_oe", 0, so_oe);
    check("status_byte", sbyte(), status_byte);
  endtask : frame

  task automatic set_write_latch_cmd();
    latch = 1'b1;
    tq = {spi_nvram_pkg::OPC_SET_LATCH};
    frame(8);
  endtask : set_write_latch_cmd

  task automatic srd();
    tq = {spi_nvram_pkg::OPC_STATUS_RD, 8'($urandom)};
    frame(16);
    check("status_rd", sbyte(), rq[1]);
  endtask : srd

  task automatic swr(input logic [7:0] d);
    if (latch && !(ppe && !wp_n)) begin
      ppe = d[7];
      bp = d[3:2];
    end
    latch = 1'b0;
    tq = {spi_nvram_pkg::OPC_STATUS_WR, d};
    frame(16);
  endtask : swr

  task automatic wr(input logic [7:0] opc, input logic [23:0] a,
                    input int n, input int cut);
    logic sec, halt;
    logic [19:0] p;
    logic [7:0] d;
    sec = opc == spi_nvram_pkg::OPC_SECTOR_WR;
    p = sec ? {12'h0, a[7:0]} : a[19:0];
    halt = !latch;
    tq = {opc, a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      tq.push_back(d);
      if (!sec && prot(p)) halt = 1'b1;
      if (!halt && !(cut > 0 && i == n - 1)) begin
        eq.push_back({sec, p, d});
        mem[key(sec, p)] = d;
        p = sec ? {12'h0, p[7:0] + 8'h1} : p + 20'h1;
      end
    end
    latch = 1'b0;
    frame(8 * tq.size() - cut);
  endtask : wr

  task automatic rd(input logic [7:0] opc, input logic [23:0] a, input int n);
    logic sec;
    logic [19:0] p;
    int h;
    sec = opc == spi_nvram_pkg::OPC_SECTOR_RD;
    p = sec ? {12'h0, a[7:0]} : a[19:0];
    tq = {opc, a[23:16], a[15:8], a[7:0]};
    if (opc == spi_nvram_pkg::OPC_FAST_READ) tq.push_back(8'h00);
    h = tq.size();
    repeat (n) tq.push_back(8'($urandom)); // noise that must be ignored
    frame(8 * tq.size());
    for (int i = 0; i < n; i++) begin
      k_rd = key(sec, p);
      check("rd_data", mem.exists(k_rd) ? mem[k_rd] : dflt(k_rd),
            rq[h + i]);
      p = sec ? {12'h0, p[7:0] + 8'h1} : p + 20'h1;
    end
  endtask : rd

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    mem_wr_ready = 1'b1;
    mem_rd_data = 8'h00;
    void'($urandom(32'hcf44));
    repeat (3) @(posedge sys_clk);
    #2 arst_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    check("status_rst", 8'h40, status_byte);
    srd();
    wr(spi_nvram_pkg::OPC_WRITE, 24'h000010, 2, 0);
    set_write_latch_cmd();
    srd();
    ra = 24'($urandom);
    wr(spi_nvram_pkg::OPC_WRITE, ra, 3, 0);
    rd(spi_nvram_pkg::OPC_READ, ra, 3);
    set_write_latch_cmd();
    wr(spi_nvram_pkg::OPC_WRITE, 24'hafffff, 3, 0);
    rd(spi_nvram_pkg::OPC_READ, 24'h5ffffe, 4);
    rd(spi_nvram_pkg::OPC_FAST_READ, 24'h0fffff, 3);
    @(posedge sys_clk) #2 wp_n = 1'b0;
    set_write_latch_cmd();
    swr(8'h87);
    set_write_latch_cmd();
    swr(8'hff);
    wr(spi_nvram_pkg::OPC_WRITE, 24'h0bfffe, 4, 0);
    set_write_latch_cmd();
    wr(spi_nvram_pkg::OPC_WRITE, 24'h0bfffe, 4, 0);
    @(posedge sys_clk) #2 wp_n = 1'b1;
    for (int b = 0; b < 4; b++) begin
      set_write_latch_cmd();
      swr({4'h0, 2'(b), 2'h0});
      set_write_latch_cmd();
      wr(spi_nvram_pkg::OPC_WRITE, {4'h0, bases[b]}, 3, 0);
    end
    rd(spi_nvram_pkg::OPC_READ, 24'h07fffe, 3);
    @(posedge sys_clk) #2 host.mode(1'b1);
    set_write_latch_cmd();
    wr(spi_nvram_pkg::OPC_SECTOR_WR, 24'habcdfe, 2, 0);
    rd(spi_nvram_pkg::OPC_SECTOR_RD, 24'h9876fe, 2);
    set_write_latch_cmd();
    swr(8'h00);
    set_write_latch_cmd();
    wr(spi_nvram_pkg::OPC_WRITE, 24'h000200, 2, 3);
    check("wr_overrun", 0, wr_overrun);
    @(posedge sys_clk) #2 mem_wr_ready = 1'b0;
    set_write_latch_cmd();
    wr(spi_nvram_pkg::OPC_WRITE, 24'h000100, 17, 0);
    check("wr_overrun", 1, wr_overrun);
    check("mem_wr_valid", 1, mem_wr_valid);
    void'(eq.pop_back());
    @(posedge sys_clk) #2 mem_wr_ready = 1'b1;
    repeat (40) @(posedge sys_clk);
    check("drained", 0, eq.size());
    results();
  end

  initial begin
    #1000000;
    num_errors++;
    results();
  end
endmodule : tb_top
